// ### rtl/cccu_top.sv
// How it works
// (R1) Remote-enter: go remote with local lockout
// (R2) Return-local: drop lockout, go local
// (R3) Clear: stop gating, flush, drop request, clear errors
// (R4) Clear: mask error-only, clear registers, ready 1
// (R5) Config block saved and restored, under 1000 chars
// (R6) Block holds setup only, no remote state
// (R7) Key query returns last key, else 0
// (R8) Key codes 1 to 17
// (R9) Request only on enabled status-A rising edge
// (R10) Mask shares status-A map, range 0..4095
// (R11) Mask parameters summed; weights 256, 32, 4
// (R12) Mask-off holds mask; mask-on replays caught edges
// (R13) Mask-on without mask-off loads error-only mask
// (R14) Mask query returns stored mask value
// (R15) Identify query returns fixed identification
// (R16) Revision query returns two date codes
// (R17) Serial number stored, quotes must match, default
// (R18) Error query returns signed value, clears it
// (R19) Ready query returns ready register 0..63
// (R20) Status-A query returns register A 0..32767
// (R21) Status-B query returns B, clears summary
// (R22) Self-test selects tests 1 to 6
// (R23) Test 1 memories; result lands in error
`timescale 1ns/1ps
module cccu_top
   import cccu_pkg::*;
#(
   parameter int          CFG_BYTES   = 16,
   parameter int          SER_LEN     = 10,
   // Identification and date codes: arbitrary values
   parameter logic [31:0] ID_CODE     = 32'h5445_5354,
   parameter logic [15:0] FW_DATE     = 16'h2912,
   parameter logic [15:0] CF_DATE     = 16'h2801,
   parameter logic [7:0]  SER_DEFAULT = 8'h30,
   parameter logic [15:0] ERR_BAD_CMD = 16'hFF9C,
   parameter logic [15:0] ERR_RANGE   = 16'hFF9B,
   parameter logic [15:0] ERR_QUOTE   = 16'hFF9A
) (
   input  wire logic                   mclk_i,
   input  wire logic                   rstn_i,
   input  wire logic [3:0]             addr_i,
   input  wire logic [31:0]            wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output logic      [31:0]            rdata_o,
   input  wire logic                   key_press_i,
   input  wire logic [4:0]             key_code_i,
   input  wire logic [STA_EVT_W-1:0]   sta_event_i,
   input  wire logic [7:0]             alarm_chg_i,
   input  wire logic [5:0]             ready_set_i,
   input  wire logic [5:0]             ready_clr_i,
   input  wire logic                   err_set_i,
   input  wire logic [15:0]            err_code_i,
   input  wire logic                   test_done_i,
   input  wire logic [15:0]            test_result_i,
   input  wire logic                   nvm_ok_i,
   output logic                        remote_o,
   output logic                        lockout_o,
   output logic                        srq_o,
   output logic                        gate_stop_o,
   output logic                        flush_o,
   output logic                        test_start_o,
   output logic      [2:0]             test_num_o,
   output logic      [CFG_BYTES*8-1:0] setup_o
);

   localparam int CFG_IW = $clog2(CFG_BYTES);
   localparam int SER_BUF = SER_LEN + 2;
   localparam int SER_IW = $clog2(SER_BUF);
   localparam logic [31:0] CFG_HEX_LEN =
      32'(CFG_HEX_HEAD + 2 * CFG_BYTES);

   // Bit31 set: arg[3:0] is a bit index
   function automatic logic [31:0] mask_weight(input logic [31:0] a);
      mask_weight = a[MNEM_FLAG_BIT] ? (32'h0000_0001 << a[3:0]) : a;
   endfunction

   function automatic logic is_quote(input logic [7:0] c);
      is_quote = (c == QUOTE_DOUBLE) || (c == QUOTE_SINGLE);
   endfunction

   // Registers
   logic [31:0]       arg_r;
   logic [31:0]       res_r;
   logic [15:0]       sta_r;
   logic [15:0]       sta_nxt;
   logic              rqs_r;
   logic              rqs_nxt;
   logic [15:0]       mask_r;
   logic [15:0]       mask_nxt;
   logic [15:0]       pend_r;
   logic [15:0]       pend_nxt;
   logic [31:0]       acc_r;
   logic [31:0]       acc_nxt;
   cccu_acc_t         acc_st_r;
   cccu_acc_t         acc_st_nxt;
   cccu_srq_t         srq_st_r;
   cccu_srq_t         srq_st_nxt;
   logic [15:0]       err_r;
   logic [15:0]       err_nxt;
   logic [4:0]        key_r;
   logic [5:0]        rdy_r;
   logic [7:0]        alm_r;
   logic [CFG_IW-1:0] cfg_idx_r;
   logic [SER_IW-1:0] ser_idx_r;
   logic [7:0]        setup_r [CFG_BYTES];
   logic [7:0]        cfg_stg_r [CFG_BYTES];
   logic [7:0]        ser_stg_r [SER_BUF];
   logic [7:0]        ser_r [SER_LEN];
   logic              ser_ok_r;
   logic [31:0]       rd_nxt;
   logic [31:0]       res_nxt;

   // Bus decode
   wire logic       cmd_go   = wr_i && (addr_i == ADDR_CMD);
   wire logic [7:0] op       = wdata_i[7:0];
   wire logic       wr_arg   = wr_i && (addr_i == ADDR_ARG);
   wire logic       wr_cidx  = wr_i && (addr_i == ADDR_CFG_IDX);
   wire logic       wr_cdat  = wr_i && (addr_i == ADDR_CFG_DATA);
   wire logic       rd_cdat  = rd_i && (addr_i == ADDR_CFG_DATA);
   wire logic       wr_sidx  = wr_i && (addr_i == ADDR_SER_IDX);
   wire logic       wr_sdat  = wr_i && (addr_i == ADDR_SER_DATA);
   wire logic       rd_sdat  = rd_i && (addr_i == ADDR_SER_DATA);

   wire logic do_clear = cmd_go && (op == OP_CLEAR);
   wire logic do_remote = cmd_go && (op == OP_REMOTE);
   wire logic do_local = cmd_go && (op == OP_LOCAL);
   wire logic do_con = cmd_go && (op == OP_CON);
   wire logic do_key_q = cmd_go && (op == OP_KEY_Q);
   wire logic do_mbegin = cmd_go && (op == OP_MASK_BEGIN);
   wire logic do_madd = cmd_go && (op == OP_MASK_ADD);
   wire logic do_mend = cmd_go && (op == OP_MASK_END);
   wire logic do_moff = cmd_go && (op == OP_MASK_OFF);
   wire logic do_mon = cmd_go && (op == OP_MASK_ON);
   wire logic do_ser = cmd_go && (op == OP_SER);
   wire logic do_err_q = cmd_go && (op == OP_ERR_Q);
   wire logic do_stb_q = cmd_go && (op == OP_STB_Q);
   wire logic do_tst = cmd_go && (op == OP_TST);

   wire logic known_op = (op >= OP_REMOTE) && (op <= OP_TST);
   wire logic [2:0] tst_sel = arg_r[2:0];
   wire logic tst_ok = (arg_r[31:3] == 29'h0) &&
                       (tst_sel >= TEST_FIRST) && (tst_sel <= TEST_LAST);
   wire logic mask_bad = acc_r > {16'h0000, MASK_MAX}; // (R10)
   wire logic [7:0] q_open = ser_stg_r[0];
   wire logic [7:0] q_close = ser_stg_r[SER_BUF-1];
   wire logic quote_ok = is_quote(q_open) && (q_open == q_close); // (R17)
   wire logic key_ok = key_press_i && (key_code_i >= KEY_FIRST) &&
                       (key_code_i <= KEY_LAST); // (R8)

   wire logic int_err = (cmd_go && !known_op) ||
                        (do_tst && !tst_ok) ||
                        (do_mend && mask_bad) ||
                        (do_ser && !quote_ok);
   wire logic [15:0] int_code =
      !known_op      ? ERR_BAD_CMD :
      do_ser         ? ERR_QUOTE   : ERR_RANGE;
   wire logic err_evt = int_err || err_set_i || test_done_i;

   // FRONT_PANEL_SETTING_SOURCE rides on a key press
   wire logic [15:0] sta_evt =
      {2'b00, sta_event_i} |
      (16'(err_evt) << STA_ERR_BIT) |
      (16'(key_ok) << STA_FPS_BIT);
   wire logic [15:0] sta_rise = sta_evt & ~sta_r; // (R9)
   wire logic [15:0] rise_en = sta_rise & mask_r; // (R10)
   wire logic [15:0] sta_view = (sta_r & ~(16'h0001 << STA_RQS_BIT)) |
                                (16'(rqs_r) << STA_RQS_BIT);
   wire logic [7:0] stb_view =
      (8'(rqs_r) << STB_RQS_BIT) |
      (8'(err_r != ERR_NONE) << STB_ERR_BIT) |
      (8'(key_r != KEY_NONE) << STB_KEY_BIT) |
      (8'(alm_r != 8'h00) << STB_ALM_BIT);

   // Sticky; a new event beats clear
   assign sta_nxt = (do_clear ? 16'h0000 : sta_r) | sta_evt; // (R4)

   // Mask handling and request generation
   always_comb begin
      mask_nxt = mask_r;
      acc_nxt = acc_r;
      acc_st_nxt = acc_st_r;
      srq_st_nxt = srq_st_r;
      pend_nxt = pend_r;
      rqs_nxt = rqs_r;
      if (srq_st_r == SRQ_HELD) begin
         pend_nxt = pend_r | rise_en; // (R12)
      end
      case (acc_st_r)
         MASK_IDLE: begin
            if (do_mbegin) begin
               acc_nxt = 32'h0000_0000;
               acc_st_nxt = MASK_ACCUM;
            end
         end
         MASK_ACCUM: begin
            if (do_madd) begin
               acc_nxt = acc_r + mask_weight(arg_r); // (R11)
            end else if (do_mend) begin
               acc_st_nxt = MASK_IDLE;
               if (!mask_bad) begin
                  mask_nxt = acc_r[15:0]; // (R10)
               end
            end else if (do_mbegin) begin
               acc_nxt = 32'h0000_0000;
            end
         end
         default: acc_st_nxt = MASK_IDLE;
      endcase
      if (do_moff) begin
         srq_st_nxt = SRQ_HELD; // (R12)
         pend_nxt = 16'h0000;
      end else if (do_mon) begin
         srq_st_nxt = SRQ_LIVE;
         if (srq_st_r == SRQ_LIVE) begin
            mask_nxt = MASK_ERR_ONLY; // (R13)
         end
      end
      if (do_clear) begin
         mask_nxt = MASK_ERR_ONLY; // (R4)
         srq_st_nxt = SRQ_LIVE;
         pend_nxt = 16'h0000;
         acc_st_nxt = MASK_IDLE;
      end
      if (do_clear || do_stb_q) begin
         rqs_nxt = 1'b0; // (R3) (R21)
      end
      // New request beats the clear
      if ((srq_st_r == SRQ_LIVE) && (|rise_en)) begin
         rqs_nxt = 1'b1; // (R9)
      end
      if (do_mon && (srq_st_r == SRQ_HELD) &&
          (|(pend_r | rise_en))) begin
         rqs_nxt = 1'b1; // (R12)
      end
   end

   // New error beats the read clear
   always_comb begin
      err_nxt = err_r;
      if (do_err_q || do_clear) begin
         err_nxt = ERR_NONE; // (R3) (R18)
      end
      if (err_set_i) begin
         err_nxt = err_code_i;
      end
      if (int_err) begin
         err_nxt = int_code;
      end
      if (test_done_i) begin
         err_nxt = test_result_i; // (R23)
      end
   end

   // Query results
   always_comb begin
      res_nxt = res_r;
      if (cmd_go) begin
         if (op == OP_CON_Q) begin
            res_nxt = CFG_HEX_LEN; // (R5)
         end else if (op == OP_KEY_Q) begin
            res_nxt = {27'h0, key_r}; // (R7)
         end else if (op == OP_MASK_Q) begin
            res_nxt = {16'h0000, mask_r}; // (R14)
         end else if (op == OP_ID_Q) begin
            res_nxt = ID_CODE; // (R15)
         end else if (op == OP_REV_Q) begin
            res_nxt = {FW_DATE, CF_DATE}; // (R16)
         end else if (op == OP_ERR_Q) begin
            res_nxt = {{16{err_r[15]}}, err_r}; // (R18)
         end else if (op == OP_RDY_Q) begin
            res_nxt = {26'h0, rdy_r}; // (R19)
         end else if (op == OP_STA_Q) begin
            res_nxt = {16'h0000, sta_view}; // (R20)
         end else if (op == OP_STB_Q) begin
            res_nxt = {24'h0, stb_view}; // (R21)
         end
      end
   end

   // Unmapped words read zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (addr_i == ADDR_ARG) begin
         rd_nxt = arg_r;
      end else if (addr_i == ADDR_RESULT) begin
         rd_nxt = res_r;
      end else if (addr_i == ADDR_STATE) begin
         rd_nxt = {27'h0, srq_st_r == SRQ_HELD, acc_st_r == MASK_ACCUM,
                   rqs_r, lockout_o, remote_o};
      end else if (addr_i == ADDR_CFG_IDX) begin
         rd_nxt = 32'(cfg_idx_r);
      end else if (addr_i == ADDR_CFG_DATA) begin
         rd_nxt = {24'h0, setup_r[cfg_idx_r]}; // (R5)
      end else if (addr_i == ADDR_SER_IDX) begin
         rd_nxt = 32'(ser_idx_r);
      end else if (addr_i == ADDR_SER_DATA) begin
         if (nvm_ok_i && ser_ok_r && (ser_idx_r < SER_IW'(SER_LEN))) begin
            rd_nxt = {24'h0, ser_r[ser_idx_r]}; // (R17)
         end else begin
            rd_nxt = {24'h0, SER_DEFAULT};
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 32'h0000_0000;
         arg_r <= 32'h0000_0000;
         res_r <= 32'h0000_0000;
      end else begin
         rdata_o <= rd_i ? rd_nxt : 32'h0000_0000;
         res_r <= res_nxt;
         if (wr_arg) begin
            arg_r <= wdata_i;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sta_r <= 16'h0000;
         rqs_r <= 1'b0;
         srq_o <= 1'b0;
         mask_r <= MASK_ERR_ONLY;
         pend_r <= 16'h0000;
         acc_r <= 32'h0000_0000;
         acc_st_r <= MASK_IDLE;
         srq_st_r <= SRQ_LIVE;
         err_r <= ERR_NONE;
      end else begin
         sta_r <= sta_nxt;
         rqs_r <= rqs_nxt;
         srq_o <= rqs_nxt; // (R9)
         mask_r <= mask_nxt;
         pend_r <= pend_nxt;
         acc_r <= acc_nxt;
         acc_st_r <= acc_st_nxt;
         srq_st_r <= srq_st_nxt;
         err_r <= err_nxt;
      end
   end

   // Key, ready, alarm registers
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         key_r <= KEY_NONE;
         rdy_r <= READY_AFTER_CLR;
         alm_r <= 8'h00;
      end else begin
         if (key_ok) begin
            key_r <= key_code_i; // (R7)
         end else if (do_key_q || do_clear) begin
            key_r <= KEY_NONE; // (R4) (R7)
         end
         if (do_clear) begin
            rdy_r <= READY_AFTER_CLR | ready_set_i; // (R4)
         end else begin
            rdy_r <= (rdy_r & ~ready_clr_i) | ready_set_i;
         end
         alm_r <= (do_clear ? 8'h00 : alm_r) | alarm_chg_i; // (R4)
      end
   end

   // Remote state, action pulses
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         remote_o <= 1'b0;
         lockout_o <= 1'b0;
         gate_stop_o <= 1'b0;
         flush_o <= 1'b0;
         test_start_o <= 1'b0;
         test_num_o <= 3'h0;
      end else begin
         if (do_remote) begin
            remote_o <= 1'b1; // (R1)
            lockout_o <= 1'b1;
         end else if (do_local) begin
            remote_o <= 1'b0; // (R2)
            lockout_o <= 1'b0;
         end
         gate_stop_o <= do_clear; // (R3)
         flush_o <= do_clear; // (R3)
         test_start_o <= do_tst && tst_ok; // (R22)
         if (do_tst && tst_ok) begin
            test_num_o <= tst_sel; // (R22) (R23)
         end
      end
   end

   // Index steps per data access
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_idx_r <= '0;
         ser_idx_r <= '0;
      end else begin
         if (wr_cidx) begin
            cfg_idx_r <= wdata_i[CFG_IW-1:0];
         end else if (wr_cdat || rd_cdat) begin
            cfg_idx_r <= cfg_idx_r + 1'b1;
         end
         if (wr_sidx) begin
            ser_idx_r <= wdata_i[SER_IW-1:0];
         end else if ((wr_sdat || rd_sdat) &&
                      (ser_idx_r < SER_IW'(SER_BUF - 1))) begin
            ser_idx_r <= ser_idx_r + 1'b1;
         end
      end
   end

   // Staged, then taken whole:
   // no half-written block escapes.
   // No remote state in it.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < CFG_BYTES; i++) begin
            setup_r[i] <= 8'h00;
            cfg_stg_r[i] <= 8'h00;
         end
      end else begin
         if (wr_cdat) begin
            cfg_stg_r[cfg_idx_r] <= wdata_i[7:0];
         end
         if (do_con) begin
            for (int i = 0; i < CFG_BYTES; i++) begin
               setup_r[i] <= cfg_stg_r[i]; // (R5) (R6)
            end
         end
      end
   end

   // Flops stand in for the store
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ser_ok_r <= 1'b0;
         for (int i = 0; i < SER_BUF; i++) begin
            ser_stg_r[i] <= 8'h00;
         end
         for (int i = 0; i < SER_LEN; i++) begin
            ser_r[i] <= 8'h00;
         end
      end else begin
         if (wr_sdat) begin
            ser_stg_r[ser_idx_r] <= wdata_i[7:0];
         end
         if (do_ser && quote_ok) begin
            ser_ok_r <= 1'b1; // (R17)
            for (int i = 0; i < SER_LEN; i++) begin
               ser_r[i] <= ser_stg_r[i+1];
            end
         end
      end
   end

   for (genvar g = 0; g < CFG_BYTES; g++) begin : g_setup
      assign setup_o[g*8 +: 8] = setup_r[g];
   end

endmodule

// ### rtl/cccu_pkg.sv
package cccu_pkg;

   // Register word index
   localparam logic [3:0] ADDR_CMD      = 4'h0;
   localparam logic [3:0] ADDR_ARG      = 4'h1;
   localparam logic [3:0] ADDR_RESULT   = 4'h2;
   localparam logic [3:0] ADDR_STATE    = 4'h3;
   localparam logic [3:0] ADDR_CFG_IDX  = 4'h4;
   localparam logic [3:0] ADDR_CFG_DATA = 4'h5;
   localparam logic [3:0] ADDR_SER_IDX  = 4'h6;
   localparam logic [3:0] ADDR_SER_DATA = 4'h7;

   // Command opcodes, bits 7:0
   localparam logic [7:0] OP_REMOTE     = 8'h01;
   localparam logic [7:0] OP_LOCAL      = 8'h02;
   localparam logic [7:0] OP_CLEAR      = 8'h03;
   localparam logic [7:0] OP_CON        = 8'h04;
   localparam logic [7:0] OP_CON_Q      = 8'h05;
   localparam logic [7:0] OP_KEY_Q      = 8'h06;
   localparam logic [7:0] OP_MASK_BEGIN = 8'h07;
   localparam logic [7:0] OP_MASK_ADD   = 8'h08;
   localparam logic [7:0] OP_MASK_END   = 8'h09;
   localparam logic [7:0] OP_MASK_OFF   = 8'h0A;
   localparam logic [7:0] OP_MASK_ON    = 8'h0B;
   localparam logic [7:0] OP_MASK_Q     = 8'h0C;
   localparam logic [7:0] OP_ID_Q       = 8'h0D;
   localparam logic [7:0] OP_REV_Q      = 8'h0E;
   localparam logic [7:0] OP_SER        = 8'h0F;
   localparam logic [7:0] OP_ERR_Q      = 8'h10;
   localparam logic [7:0] OP_RDY_Q      = 8'h11;
   localparam logic [7:0] OP_STA_Q      = 8'h12;
   localparam logic [7:0] OP_STB_Q      = 8'h13;
   localparam logic [7:0] OP_TST        = 8'h14;

   // Mask and status A layout
   localparam logic [15:0] MASK_MAX      = 16'h0FFF;
   localparam logic [15:0] MASK_ERR_ONLY = 16'h0020;
   localparam int          STA_FPS_BIT   = 2;
   localparam int          STA_ERR_BIT   = 5;
   localparam int          STA_EOG_BIT   = 8;
   localparam int          STA_RQS_BIT   = 14;
   localparam int          STA_EVT_W     = 14;
   localparam int          MNEM_FLAG_BIT = 31;

   // Status register B layout
   localparam int STB_ALM_BIT = 3;
   localparam int STB_KEY_BIT = 4;
   localparam int STB_ERR_BIT = 5;
   localparam int STB_RQS_BIT = 6;

   localparam logic [5:0]  READY_AFTER_CLR = 6'h01;
   localparam logic [4:0]  KEY_NONE        = 5'h00;
   localparam logic [4:0]  KEY_FIRST       = 5'h01;
   localparam logic [4:0]  KEY_LAST        = 5'h11;
   localparam logic [2:0]  TEST_FIRST      = 3'h1;
   localparam logic [2:0]  TEST_LAST       = 3'h6;
   localparam logic [7:0]  QUOTE_DOUBLE    = 8'h22;
   localparam logic [7:0]  QUOTE_SINGLE    = 8'h27;
   localparam logic [15:0] ERR_NONE        = 16'h0000;
   localparam int          CFG_HEX_LIMIT   = 1000;
   localparam int          CFG_HEX_HEAD    = 2;

   typedef enum logic {MASK_IDLE, MASK_ACCUM} cccu_acc_t;
   typedef enum logic {SRQ_LIVE, SRQ_HELD} cccu_srq_t;

endpackage

// ### verification/cccu_top_chk.sv
`timescale 1ns/1ps
module cccu_top_chk
   import cccu_pkg::*;
#(
   parameter int CFG_BYTES = 16
) (
   input wire logic                   mclk_i,
   input wire logic                   rstn_i,
   input wire logic [3:0]             addr_i,
   input wire logic [31:0]            wdata_i,
   input wire logic                   wr_i,
   input wire logic                   remote_o,
   input wire logic                   lockout_o,
   input wire logic                   gate_stop_o,
   input wire logic                   flush_o,
   input wire logic                   test_start_o,
   input wire logic [2:0]             test_num_o,
   input wire logic [CFG_BYTES*8-1:0] setup_o
);
   logic [31:0] arg_r;
   wire         cmd_w = wr_i && (addr_i == ADDR_CMD);
   wire         clr_w = cmd_w && (wdata_i[7:0] == OP_CLEAR);
   wire         tst_w = cmd_w && (wdata_i[7:0] == OP_TST);
   wire         rmt_w = cmd_w && (wdata_i[7:0] == OP_REMOTE);
   wire         lcl_w = cmd_w && (wdata_i[7:0] == OP_LOCAL);
   wire [2:0]   num_w = arg_r[2:0];
   wire         ok_w  = (arg_r[31:3] == 29'h0000_0000)
                        && (num_w >= TEST_FIRST) && (num_w <= TEST_LAST);
   // Mirror of the argument the next command consumes
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         arg_r <= 32'h0000_0000;
      end else if (wr_i && (addr_i == ADDR_ARG)) begin
         arg_r <= wdata_i;
      end
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);
   property p_rmt; rmt_w |=> remote_o && lockout_o; endproperty
   a_rmt: assert property (p_rmt) else $error("remote entry missed");
   property p_lcl; lcl_w |=> !remote_o && !lockout_o; endproperty
   a_lcl: assert property (p_lcl) else $error("local return missed");
   property p_hold; !rmt_w && !lcl_w |=> $stable(lockout_o); endproperty
   a_hold: assert property (p_hold) else $error("lockout moved");
   property p_clr; clr_w |=> gate_stop_o && flush_o && $stable(setup_o);
   endproperty
   a_clr: assert property (p_clr) else $error("clear effects wrong");
   property p_gate; gate_stop_o || flush_o |-> $past(clr_w); endproperty
   a_gate: assert property (p_gate) else $error("stray stop pulse");
   property p_tst; tst_w && ok_w |=> test_start_o && test_num_o == $past(num_w);
   endproperty
   a_tst: assert property (p_tst) else $error("test not started");
   property p_bad; tst_w && !ok_w |=> !test_start_o ##0 $stable(test_num_o);
   endproperty
   a_bad: assert property (p_bad) else $error("bad test taken");
   property p_start; test_start_o |-> $past(tst_w) && $past(ok_w); endproperty
   a_start: assert property (p_start) else $error("stray test start");
   c_clr: cover property (clr_w ##1 gate_stop_o);
   c_tst: cover property (tst_w ##1 test_start_o);
   c_rmt: cover property (rmt_w ##1 lockout_o);
endmodule
bind cccu_top cccu_top_chk #(.CFG_BYTES(CFG_BYTES)) u_chk (.*);

// ### verification/cccu_selftest_model.sv
`timescale 1ns/1ps
module cccu_selftest_model #(
   parameter logic [15:0] FAIL_CODE = 16'h0007
) (
   input  wire logic        mclk_i,
   input  wire logic        rstn_i,
   input  wire logic        test_start_i,
   input  wire logic        fail_i,
   input  wire logic        slow_i,
   output logic             test_done_o,
   output logic      [15:0] test_result_o
);
   logic [3:0]  dly_r;
   logic [15:0] res_r;
   assign test_done_o = (dly_r == 4'h1);
   // Garbage outside done
   assign test_result_o = test_done_o ? res_r : ~res_r;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dly_r <= 4'h0;
         res_r <= 16'h0000;
      end else if (test_start_i) begin
         dly_r <= slow_i ? 4'hC : 4'h2;
         res_r <= fail_i ? FAIL_CODE : 16'h0000;
      end else if (dly_r != 4'h0) begin
         dly_r <= dly_r - 4'h1;
      end
   end
endmodule

// ### verification/test_common_capability_command_unit.sv
`timescale 1ns/1ps
module test_common_capability_command_unit
   import cccu_pkg::*;
;
   localparam logic [31:0] ID_EXP = 32'h4142_4344; // Arbitrary value
   logic         mclk_i, rstn_i, wr_i, rd_i, key_press_i, nvm_ok_i;
   logic         fail_r, slow_r, test_done_i, test_start_o, srq_o;
   logic [3:0]   addr_i;
   logic [31:0]  wdata_i, rdata_o;
   logic [4:0]   key_code_i;
   logic [13:0]  sta_event_i;
   logic [15:0]  test_result_i;
   logic [2:0]   test_num_o;
   logic [127:0] setup_o;
   int           miscompares, tests_run;
   cccu_top #(.ID_CODE(ID_EXP)) uut (
      .*, .alarm_chg_i(8'h00), .ready_set_i(6'h00), .ready_clr_i(6'h00),
      .err_set_i(1'h0), .err_code_i(16'h0000), .remote_o(), .lockout_o(),
      .gate_stop_o(), .flush_o()
   );
   cccu_selftest_model st (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .test_start_i(test_start_o),
      .fail_i(fail_r), .slow_i(slow_r), .test_done_o(test_done_i),
      .test_result_o(test_result_i)
   );
   task automatic chk(input string nm, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic complete_run;
      if (miscompares == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'h1;
      rd_i    <= 1'h0;
      @(posedge mclk_i);
   endtask
   task automatic idle;
      wr_i <= 1'h0;
      rd_i <= 1'h0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      addr_i <= a;
      wr_i   <= 1'h0;
      rd_i   <= 1'h1;
      @(posedge mclk_i);
      rd_i <= 1'h0;
      #1;
      chk("rdata_o", rdata_o, e);
   endtask
   task automatic cmd(input logic [7:0] op);
      wr(ADDR_CMD, {24'h00_0000, op});
   endtask
   task automatic q(input logic [7:0] op, input logic [31:0] e);
      cmd(op);
      rd(ADDR_RESULT, e);
   endtask
   task automatic mask(input logic [31:0] v);
      wr(ADDR_ARG, v);
      cmd(OP_MASK_BEGIN);
      cmd(OP_MASK_ADD);
      cmd(OP_MASK_END);
   endtask
   task automatic ev(input logic [13:0] s);
      sta_event_i <= s;
      idle;
      sta_event_i <= 14'h0000;
      repeat (3) idle;
   endtask
   task automatic key(input logic [4:0] c);
      key_code_i  <= c;
      key_press_i <= 1'h1;
      idle;
      key_press_i <= 1'h0;
      idle;
   endtask
   task automatic wait_done;
      #1;
      for (int t = 0; t < 20 && test_done_i !== 1'h1; t++) #10;
      @(posedge mclk_i);
   endtask
   initial begin
      mclk_i = 1'h0;
      forever #5 mclk_i = ~mclk_i;
   end
   initial begin
      repeat (6000) @(posedge mclk_i);
      miscompares++;
      complete_run;
   end
   initial begin
      {rstn_i, wr_i, rd_i, key_press_i, fail_r, slow_r} = 6'h00;
      {addr_i, wdata_i, key_code_i, sta_event_i} = '0;
      nvm_ok_i = 1'h1;
      miscompares = 0;
      tests_run = 0;
      repeat (2) @(posedge mclk_i);
      rstn_i <= 1'h1;
      q(OP_KEY_Q, 32'h0000_0000);
      q(OP_MASK_Q, 32'h0000_0020);
      q(OP_ID_Q, ID_EXP);
      cmd(OP_REMOTE);
      rd(ADDR_STATE, 32'h0000_0003);
      cmd(OP_LOCAL);
      rd(ADDR_STATE, 32'h0000_0000);
      wr(ADDR_ARG, 32'h0000_0100);
      cmd(OP_MASK_BEGIN);
      cmd(OP_MASK_ADD);
      wr(ADDR_ARG, 32'h8000_0005);
      cmd(OP_MASK_ADD);
      wr(ADDR_ARG, 32'h0000_0004);
      cmd(OP_MASK_ADD);
      cmd(OP_MASK_END);
      q(OP_MASK_Q, 32'h0000_0124);
      mask(32'h0000_1000);
      q(OP_MASK_Q, 32'h0000_0124);
      cmd(OP_ERR_Q);
      q(OP_ERR_Q, 32'h0000_0000);
      mask(32'h0000_0FFF);
      q(OP_MASK_Q, 32'h0000_0FFF);
      key(5'h11);
      q(OP_KEY_Q, 32'h0000_0011);
      q(OP_KEY_Q, 32'h0000_0000);
      key(5'h12);
      q(OP_KEY_Q, 32'h0000_0000);
      wr(ADDR_CFG_IDX, 32'h0000_0000);
      for (int i = 0; i < 16; i++) wr(ADDR_CFG_DATA, 32'h0000_00A0 + i);
      cmd(OP_CON);
      q(OP_CON_Q, 32'h0000_0022);
      chk("setup_o", setup_o[31:0], 32'hA3A2_A1A0);
      wr(ADDR_ARG, 32'h0000_0007);
      cmd(OP_TST);
      cmd(OP_CLEAR);
      q(OP_MASK_Q, 32'h0000_0020);
      q(OP_RDY_Q, 32'h0000_0001);
      q(OP_STA_Q, 32'h0000_0000);
      q(OP_ERR_Q, 32'h0000_0000);
      rd(ADDR_STATE, 32'h0000_0000);
      chk("setup_o", setup_o[127:96], 32'hAFAE_ADAC);
      chk("test_num_o", 32'(test_num_o), 32'h0000_0000);
      mask(32'h0000_0124);
      ev(14'h0001);
      rd(ADDR_STATE, 32'h0000_0000);
      ev(14'h0100);
      rd(ADDR_STATE, 32'h0000_0004);
      chk("srq_o", 32'(srq_o), 32'h0000_0001);
      cmd(OP_STB_Q);
      rd(ADDR_STATE, 32'h0000_0000);
      chk("srq_o", 32'(srq_o), 32'h0000_0000);
      cmd(OP_MASK_OFF);
      q(OP_MASK_Q, 32'h0000_0124);
      ev(14'h0004);
      rd(ADDR_STATE, 32'h0000_0010);
      cmd(OP_MASK_ON);
      idle;
      rd(ADDR_STATE, 32'h0000_0004);
      cmd(OP_MASK_ON);
      q(OP_MASK_Q, 32'h0000_0020);
      wr(ADDR_SER_IDX, 32'h0000_0000);
      for (int i = 0; i < 12; i++)
         wr(ADDR_SER_DATA, (i % 11 == 0) ? 32'h0000_0027 : 32'h0000_0041 + i);
      cmd(OP_SER);
      wr(ADDR_SER_IDX, 32'h0000_0000);
      rd(ADDR_SER_DATA, 32'h0000_0042);
      nvm_ok_i <= 1'h0;
      wr(ADDR_SER_IDX, 32'h0000_0000);
      rd(ADDR_SER_DATA, 32'h0000_0030);
      for (int n = 1; n < 7; n++) begin
         fail_r <= (n == 6);
         slow_r <= n[0];
         wr(ADDR_ARG, n);
         cmd(OP_TST);
         idle;
         wait_done;
         chk("test_num_o", 32'(test_num_o), n);
         q(OP_ERR_Q, (n == 6) ? 32'h0000_0007 : 32'h0000_0000);
      end
      complete_run;
   end
endmodule
